// [rtl/omc_cfg_top.v]
// output macrocell configuration logic with AXI4-Lite register access
// Function
// (RQ1) three global modes, simple, complex, registered, applied to all cells together
// (RQ2) sync select bit and global arch bit jointly choose the mode
// (RQ3) per-cell polarity bit inverts its output in every mode
// (RQ4) per-cell local arch bit picks input or output role within the mode
// (RQ5) configuration is two global bits plus sixteen per-cell bits
// (RQ6) registered mode: fixed pins become shared clock and output enable
// (RQ7) complex mode: clock and oe pins enter via outermost cells' feedback
// (RQ8) simple mode: feedback via neighbour cell; two inner cells have none
// (RQ9) registered cells clocked by shared clock, enabled by shared oe pin
// (RQ10) registered mode: each cell registered output or combinatorial io
// (RQ11) registered mode: registered gets eight terms, io gets seven plus enable
// (RQ12) complex mode: at most six inputs, outer cells cannot be inputs
// (RQ13) complex mode: seven sum terms plus one output enable term per cell
// (RQ14) complex and simple modes: clock and oe pins are plain data inputs
// (RQ15) simple mode: cells are dedicated inputs or always-driven outputs
// (RQ16) simple mode: up to eight sum terms, polarity kept
// (RQ17) simple mode: centre two cells never inputs
// (RQ18) power-down pin never feeds the logic array
// (RQ19) outside party drives power-down pin high to sleep, low to run
// (RQ20) unused fourth mode bit combination decodes as simple mode
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "omc_cfg_regs.vh"

module omc_cfg_top #(
    parameter NCELL = 8
) (
    input wire clk_sys,
    input wire rst_n,
    input wire clkEn,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // device pins and array
    input wire clkPin,
    input wire oePin,
    input wire powerDownPin,
    input wire [NCELL-1:0] sumIn,
    input wire [NCELL-1:0] oeTermIn,
    input wire [NCELL-1:0] ioPinIn,
    output reg [NCELL-1:0] ioPinOut,
    output reg [NCELL-1:0] ioPinOe,
    output reg [NCELL-1:0] feedbackOut,
    output reg [1:0] dataPinsOut,
    output reg [1:0] modeOut,
    output reg [NCELL-1:0] inputCapOut,
    output reg cfgErrorOut
);

    // configuration storage: two global bits and two bits per cell
    reg syncModeSelectBit_q; // (RQ5)
    reg globalArchControlBit_q;
    reg [NCELL-1:0] polarity_q;
    reg [NCELL-1:0] localArchControlBit_q;
    reg [NCELL-1:0] cellReg_q;
    reg clkPinDly_q;
    reg cfgError_q;

    // bus state
    reg awHeld_q;
    reg wHeld_q;
    reg [7:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;

    // reset value of the global pair, split into its two fields below
    localparam [1:0] RST_GLB = `OMC_RST_GLOBAL;

    // mode table for the global pair:
    //   sync 0, arch 0 -> registered, the state left by reset
    //   sync 0, arch 1 -> complex
    //   sync 1, arch x -> simple; the fourth code lands here too
    // all cells switch together; there is no per-cell mode
    //
    // local arch bit per cell, 1 = input or io, 0 = output:
    //   registered: 0 = registered output, 1 = combinatorial io
    //   complex: 0 = output only, 1 = io; outer cells stay 0
    //   simple: 0 = driven output, 1 = dedicated input
    //   simple: centre cells stay 0
    // forbidden roles are flagged, not blocked, so software
    // sees a bad image instead of a silent fix-up
    //
    // cells 0 and NCELL-1 are the outer cells,
    // NCELL/2-1 and NCELL/2 are the centre cells
    //
    // product terms per cell, as shown in the count word:
    //   registered output: eight in the sum
    //   combinatorial io: seven in the sum, one for enable
    //   complex cell: seven in the sum, one for enable
    //   simple output: eight in the sum, no enable term
    //   simple input: none
    //
    // the shared clock pin is a level sampled on clk_sys;
    // pulses shorter than one clk_sys period can be missed,
    // a limit the board must respect
    //
    // the power-down pin is reported in status only; nothing
    // in the datapath reads it, so it never acts as array data

    // mode decode, shared by datapath and status
    function [1:0] decodeMode;
        input syncBit;
        input archBit;
        begin
            if (syncBit == 1'b0 && archBit == 1'b1) begin // (RQ2)
                decodeMode = `OMC_MODE_COMPLEX;
            end else if (syncBit == 1'b0 && archBit == 1'b0) begin
                decodeMode = `OMC_MODE_REG;
            end else begin
                decodeMode = `OMC_MODE_SIMPLE; // (RQ20)
            end
        end
    endfunction

    // index of the cell whose feedback a cell uses in simple mode
    function integer neighbour;
        input integer idx;
        begin
            if (idx < NCELL / 2) begin
                neighbour = idx + 1;
            end else begin
                neighbour = idx - 1;
            end
        end
    endfunction

    wire [1:0] mode = decodeMode(syncModeSelectBit_q, globalArchControlBit_q); // (RQ1)
    wire isReg = (mode == `OMC_MODE_REG);
    wire isCplx = (mode == `OMC_MODE_COMPLEX);
    wire isSimple = (mode == `OMC_MODE_SIMPLE);
    // the shared clock pin is sampled on clk_sys; a rising edge advances registered cells
    wire clkRise = clkPin & ~clkPinDly_q; // (RQ9)

    // per-cell combinational view of each mode
    reg [NCELL-1:0] outVal;
    reg [NCELL-1:0] outEn;
    reg [NCELL-1:0] fbVal;
    reg [NCELL-1:0] inCap;
    reg badCfg;
    integer i;
    always @* begin
        outVal = {NCELL{1'b0}};
        outEn = {NCELL{1'b0}};
        fbVal = {NCELL{1'b0}};
        inCap = {NCELL{1'b0}};
        badCfg = 1'b0;
        for (i = 0; i < NCELL; i = i + 1) begin
            if (isReg) begin
                if (localArchControlBit_q[i] == 1'b0) begin // (RQ10)
                    // registered: full eight-term sum, shared oe pin (active low)
                    outVal[i] = cellReg_q[i] ^ polarity_q[i]; // (RQ3)
                    outEn[i] = ~oePin; // (RQ9)
                    fbVal[i] = cellReg_q[i];
                end else begin
                    // combinatorial io: seven terms plus one enable term
                    outVal[i] = sumIn[i] ^ polarity_q[i]; // (RQ11)
                    outEn[i] = oeTermIn[i];
                    fbVal[i] = ioPinIn[i];
                    inCap[i] = 1'b1;
                end
            end else if (isCplx) begin
                outVal[i] = sumIn[i] ^ polarity_q[i]; // (RQ13)
                outEn[i] = oeTermIn[i];
                if (i == 0) begin
                    fbVal[i] = clkPin; // (RQ7)
                    badCfg = badCfg | localArchControlBit_q[i]; // (RQ12)
                end else if (i == NCELL - 1) begin
                    fbVal[i] = oePin; // (RQ7)
                    badCfg = badCfg | localArchControlBit_q[i]; // (RQ12)
                end else begin
                    fbVal[i] = ioPinIn[i];
                    inCap[i] = localArchControlBit_q[i];
                end
            end else begin
                // simple: dedicated input or always-driven output
                if (i == NCELL / 2 - 1 || i == NCELL / 2) begin
                    badCfg = badCfg | localArchControlBit_q[i]; // (RQ17)
                    outVal[i] = sumIn[i] ^ polarity_q[i];
                    outEn[i] = 1'b1;
                    fbVal[i] = 1'b0; // (RQ8)
                end else if (localArchControlBit_q[i]) begin
                    outEn[i] = 1'b0; // (RQ15)
                    inCap[i] = 1'b1;
                    fbVal[i] = ioPinIn[neighbour(i)]; // (RQ8)
                end else begin
                    outVal[i] = sumIn[i] ^ polarity_q[i]; // (RQ16)
                    outEn[i] = 1'b1; // (RQ15)
                    fbVal[i] = ioPinIn[neighbour(i)]; // (RQ8)
                end
            end
        end
    end

    // datapath registers; powerDownPin is deliberately not an array input
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cellReg_q <= {NCELL{1'b0}};
            clkPinDly_q <= 1'b0;
            ioPinOut <= {NCELL{1'b0}};
            ioPinOe <= {NCELL{1'b0}};
            feedbackOut <= {NCELL{1'b0}};
            dataPinsOut <= 2'h0;
            modeOut <= `OMC_MODE_SIMPLE;
            inputCapOut <= {NCELL{1'b0}};
            cfgError_q <= 1'b0;
            cfgErrorOut <= 1'b0;
        end else if (clkEn) begin
            clkPinDly_q <= clkPin;
            if (isReg && clkRise) begin
                cellReg_q <= sumIn; // (RQ6)
            end
            ioPinOut <= outVal;
            ioPinOe <= outEn;
            feedbackOut <= fbVal;
            // in registered mode the two pins are control only, never data
            dataPinsOut <= isReg ? 2'h0 : {oePin, clkPin}; // (RQ14)
            modeOut <= mode;
            inputCapOut <= inCap;
            cfgError_q <= badCfg;
            cfgErrorOut <= badCfg;
        end
    end

    // register map, byte addresses, one word each:
    //   0x00 global pair, bit 0 sync select, bit 1 global arch
    //   0x04 polarity, one bit per cell, 1 inverts
    //   0x08 local arch bits, one per cell
    //   0x0c status, read only: [1:0] mode, [2] config error,
    //        [3] power-down level, [15:8] input-capable cells
    //   0x10 product term counts, four bits per cell
    //   0x14 feedback values into the array
    // writes to read-only or unmapped words answer SLVERR
    // and change nothing
    //
    // write handshake, one cycle per step:
    //   c0 awvalid and wvalid seen
    //   c1 awready and wready pulse high
    //   c2 address and data held, readies low
    //   c3 register updated, bvalid high until bready
    // the two halves may also come apart, in either order
    //
    // ready pulses last one cycle on purpose: a master that
    // keeps valid up a cycle too long is not taken twice

    // write path: address and data taken in either order, answered once both held
    wire wrGo = awHeld_q & wHeld_q & ~s_axi_bvalid;
    wire [31:0] wdMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `OMC_RESP_OKAY;
            syncModeSelectBit_q <= RST_GLB[`OMC_GLB_SYNC_BIT];
            globalArchControlBit_q <= RST_GLB[`OMC_GLB_ARCH_BIT];
            polarity_q <= `OMC_RST_POLARITY;
            localArchControlBit_q <= `OMC_RST_LOCALAC;
        end else if (clkEn) begin
            s_axi_awready <= ~awHeld_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~wHeld_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrGo) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `OMC_RESP_OKAY;
                case (awAddr_q & 8'hfc)
                    `OMC_ADDR_GLOBAL: begin
                        if (wStrb_q[0]) begin
                            syncModeSelectBit_q <= wData_q[`OMC_GLB_SYNC_BIT]; // (RQ2)
                            globalArchControlBit_q <= wData_q[`OMC_GLB_ARCH_BIT];
                        end
                    end
                    `OMC_ADDR_POLARITY: begin
                        polarity_q <= (polarity_q & ~wdMask[NCELL-1:0]) | (wData_q[NCELL-1:0] & wdMask[NCELL-1:0]);
                    end
                    `OMC_ADDR_LOCALAC: begin
                        localArchControlBit_q <= (localArchControlBit_q & ~wdMask[NCELL-1:0])
                            | (wData_q[NCELL-1:0] & wdMask[NCELL-1:0]); // (RQ4)
                    end
                    default: begin
                        s_axi_bresp <= `OMC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // product term counts per cell for the status view, four bits each
    reg [31:0] ptWord;
    integer k;
    always @* begin
        ptWord = 32'h00000000;
        for (k = 0; k < NCELL; k = k + 1) begin
            if (isReg && !localArchControlBit_q[k]) begin
                ptWord[k*4 +: 4] = `OMC_PT_FULL; // (RQ11)
            end else if (isSimple) begin
                ptWord[k*4 +: 4] = localArchControlBit_q[k] ? 4'h0 : `OMC_PT_FULL; // (RQ16)
            end else begin
                ptWord[k*4 +: 4] = `OMC_PT_OE; // (RQ13)
            end
        end
    end

    // read handshake:
    //   c0 arvalid seen
    //   c1 arready pulses high
    //   c2 rvalid high with rdata, held until rready
    // status and counts come live from the decode, so a read
    // right after a write already sees the new mode

    // read path: one-cycle arready pulse, data the next edge
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `OMC_RESP_OKAY;
        end else if (clkEn) begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `OMC_RESP_OKAY;
                case (s_axi_araddr & 8'hfc)
                    `OMC_ADDR_GLOBAL: s_axi_rdata <= {30'h0, globalArchControlBit_q, syncModeSelectBit_q};
                    `OMC_ADDR_POLARITY: s_axi_rdata <= {{(32-NCELL){1'b0}}, polarity_q};
                    `OMC_ADDR_LOCALAC: s_axi_rdata <= {{(32-NCELL){1'b0}}, localArchControlBit_q};
                    `OMC_ADDR_STATUS: s_axi_rdata <= {16'h0, inCap, 4'h0, powerDownPin, cfgError_q, mode}; // (RQ18)
                    `OMC_ADDR_PTCOUNT: s_axi_rdata <= ptWord;
                    `OMC_ADDR_INPUT: s_axi_rdata <= {{(32-NCELL){1'b0}}, fbVal};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `OMC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // omc_cfg_top

// [pkg/omc_cfg_regs.vh]
// register offsets, field positions, reset values and mode codes for the output macrocell configuration block
`ifndef OMC_CFG_REGS_VH
`define OMC_CFG_REGS_VH

// byte offsets on the register bus
`define OMC_ADDR_GLOBAL   8'h00
`define OMC_ADDR_POLARITY 8'h04
`define OMC_ADDR_LOCALAC  8'h08
`define OMC_ADDR_STATUS   8'h0c
`define OMC_ADDR_PTCOUNT  8'h10
`define OMC_ADDR_INPUT    8'h14

// fields of the global register
`define OMC_GLB_SYNC_BIT  0
`define OMC_GLB_ARCH_BIT  1

// reset values: registered mode, no inversion, all cells outputs
`define OMC_RST_GLOBAL    2'h0
`define OMC_RST_POLARITY  8'h00
`define OMC_RST_LOCALAC   8'h00

// mode codes, as reported in status bits 1:0
`define OMC_MODE_SIMPLE   2'h0
`define OMC_MODE_COMPLEX  2'h1
`define OMC_MODE_REG      2'h2

// product term counts
`define OMC_PT_FULL       4'h8
`define OMC_PT_OE         4'h7

// bus responses
`define OMC_RESP_OKAY     2'h0
`define OMC_RESP_SLVERR   2'h2

`endif

// [tb/omc_cfg_checker.sv]
// concurrent checks on the ports of the output macrocell configuration block
`timescale 1ns/1ns
module omc_cfg_checker #(
    parameter NCELL = 8
) (
    input wire clk_sys,
    input wire rst_n,
    input wire clkEn,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire clkPin,
    input wire oePin,
    input wire [NCELL-1:0] sumIn,
    input wire [NCELL-1:0] oeTermIn,
    input wire [NCELL-1:0] ioPinOut,
    input wire [NCELL-1:0] ioPinOe,
    input wire [NCELL-1:0] feedbackOut,
    input wire [NCELL-1:0] inputCapOut,
    input wire [1:0] dataPinsOut,
    input wire [1:0] modeOut
);
    // a write response marks a config change, so windows around it are skipped
    wire steady = rst_n && clkEn && !s_axi_bvalid;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_mode_legal: assert property (modeOut != 2'h3)
        else $error("mode code out of range");
    a_reg_pins_off: assert property (steady [*2] ##0 modeOut == 2'h2 |-> dataPinsOut == 2'h0)
        else $error("clock and enable pins reach the array in registered mode");
    a_data_pins: assert property (steady [*2] ##0 modeOut != 2'h2 |-> dataPinsOut == $past({oePin, clkPin}))
        else $error("clock and enable pins not passed as data");
    a_simple_drive: assert property (steady [*2] ##0 modeOut == 2'h0 |-> ((ioPinOe ^ ~inputCapOut) & 8'he7) == 8'h00)
        else $error("simple cell neither input nor driven output");
    a_simple_inner: assert property (steady [*2] ##0 modeOut == 2'h0 |-> ioPinOe[4:3] == 2'h3)
        else $error("centre cell not driving in simple mode");
    a_complex_fb: assert property (steady [*2] ##0 modeOut == 2'h1 |->
        feedbackOut[0] == $past(clkPin) && feedbackOut[NCELL-1] == $past(oePin))
        else $error("outer feedback does not carry the pins");
    a_reg_oe_off: assert property (steady [*2] ##0 modeOut == 2'h2 && $past(oePin) && $past(oeTermIn) == '0
        |-> ioPinOe == '0)
        else $error("cell driven with shared enable off");
    a_simple_pol: assert property (steady [*3] ##0 modeOut == 2'h0 && $past(modeOut) == 2'h0 |->
        ((ioPinOut ^ $past(sumIn)) & ioPinOe) == (($past(ioPinOut) ^ $past(sumIn, 2)) & ioPinOe))
        else $error("output is not a fixed inversion of its sum");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clkEn |=> s_axi_rvalid)
        else $error("read answer late");
    a_ready_pulse: assert property (s_axi_awready && clkEn |=> !s_axi_awready)
        else $error("write address ready held");
endmodule // omc_cfg_checker

bind omc_cfg_top omc_cfg_checker #(.NCELL(NCELL)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .clkPin(clkPin), .oePin(oePin),
    .sumIn(sumIn), .oeTermIn(oeTermIn), .ioPinOut(ioPinOut), .ioPinOe(ioPinOe), .feedbackOut(feedbackOut),
    .inputCapOut(inputCapOut), .dataPinsOut(dataPinsOut), .modeOut(modeOut));

// [tb/omc_board_model.sv]
// board-side model: makes the shared clock pin, the power-down level and the pin levels
`timescale 1ns/1ns
module omc_board_model (
    input wire clk_sys,
    input wire runClk,
    input wire pdReq,
    input wire [7:0] extIn,
    input wire [7:0] ioPinOut,
    input wire [7:0] ioPinOe,
    output logic clkPin,
    output wire powerDownPin,
    output wire [7:0] ioPinIn
);
    // clock stands low outside bursts so no stray register load happens
    initial clkPin = 1'b0;
    always @(posedge clk_sys) clkPin <= runClk ? ~clkPin : 1'b0;
    assign powerDownPin = pdReq;
    // an undriven pin shows the board's own level
    assign ioPinIn = (ioPinOut & ioPinOe) | (extIn & ~ioPinOe);
endmodule // omc_board_model

// [tb/tb_top.sv]
// self-checking bench for the output macrocell configuration block
`timescale 1ns/1ns
`include "omc_cfg_regs.vh"
`define CHK(n, g, e) chk(n, 32'(g), 32'(e))
module tb_top;
    logic clk_sys, rst_n, clkEn, oePin, runClk, pdReq;
    logic [7:0] s_axi_awaddr, s_axi_araddr, sumIn, oeTermIn, extIn;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, clkPin, powerDownPin, cfgErrorOut;
    wire [1:0] s_axi_bresp, s_axi_rresp, dataPinsOut, modeOut;
    wire [31:0] s_axi_rdata;
    wire [7:0] ioPinIn, ioPinOut, ioPinOe, feedbackOut, inputCapOut;
    int miscompares, check_count;
    omc_cfg_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .clkPin(clkPin), .oePin(oePin), .powerDownPin(powerDownPin),
        .sumIn(sumIn), .oeTermIn(oeTermIn), .ioPinIn(ioPinIn), .ioPinOut(ioPinOut), .ioPinOe(ioPinOe),
        .feedbackOut(feedbackOut), .dataPinsOut(dataPinsOut), .modeOut(modeOut), .inputCapOut(inputCapOut),
        .cfgErrorOut(cfgErrorOut));
    omc_board_model board (.clk_sys(clk_sys), .runClk(runClk), .pdReq(pdReq), .extIn(extIn),
        .ioPinOut(ioPinOut), .ioPinOe(ioPinOe), .clkPin(clkPin), .powerDownPin(powerDownPin), .ioPinIn(ioPinIn));
    task automatic chk(string nm, logic [31:0] g, logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // write: address and data offered together, each dropped once taken; ready lines stay high
    task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        `CHK("bresp", s_axi_bresp, er);
    endtask
    task automatic axr(logic [7:0] a, logic [31:0] m, logic [31:0] e, logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        `CHK("rdata", s_axi_rdata & m, e);
        `CHK("rresp", s_axi_rresp, er);
    endtask
    task automatic t_regs();
        axr(`OMC_ADDR_GLOBAL, 32'hffff_ffff, `OMC_RST_GLOBAL, `OMC_RESP_OKAY);
        axr(`OMC_ADDR_POLARITY, 32'hffff_ffff, `OMC_RST_POLARITY, `OMC_RESP_OKAY);
        axr(`OMC_ADDR_LOCALAC, 32'hffff_ffff, `OMC_RST_LOCALAC, `OMC_RESP_OKAY);
        axw(`OMC_ADDR_POLARITY, 32'hffff_ff5a, `OMC_RESP_OKAY);
        axr(`OMC_ADDR_POLARITY, 32'h0000_00ff, 32'h0000_005a, `OMC_RESP_OKAY);
        axw(`OMC_ADDR_STATUS, 32'h0000_0001, `OMC_RESP_SLVERR);
        axw(8'h20, 32'h0000_0001, `OMC_RESP_SLVERR);
        axr(8'h20, 32'h0000_0000, 32'h0000_0000, `OMC_RESP_SLVERR);
    endtask
    // every code of the two global bits, the fourth one included
    task automatic t_modes();
        logic [1:0] md;
        for (int g = 0; g < 4; g++) begin
            md = g[0] ? `OMC_MODE_SIMPLE : (g[1] ? `OMC_MODE_COMPLEX : `OMC_MODE_REG);
            axw(`OMC_ADDR_GLOBAL, 32'(g), `OMC_RESP_OKAY);
            tick(3);
            axr(`OMC_ADDR_STATUS, 32'h0000_0003, 32'(md), `OMC_RESP_OKAY);
            `CHK("mode", modeOut, md);
        end
    endtask
    // outer cells inputs, power-down held high to show it changes nothing
    task automatic t_simple();
        axw(`OMC_ADDR_GLOBAL, 32'h0000_0001, `OMC_RESP_OKAY);
        axw(`OMC_ADDR_POLARITY, 32'h0000_000f, `OMC_RESP_OKAY);
        axw(`OMC_ADDR_LOCALAC, 32'h0000_0081, `OMC_RESP_OKAY);
        sumIn <= 8'h3c;
        oePin <= 1'b1;
        pdReq <= 1'b1;
        tick(3);
        `CHK("oe", ioPinOe, 8'h7e);
        `CHK("out", ioPinOut & ioPinOe, 8'h32);
        `CHK("incap", inputCapOut, 8'h81);
        `CHK("fb", feedbackOut & 8'he7, 8'h61);
        `CHK("data", dataPinsOut, 2'h2);
        axr(`OMC_ADDR_STATUS, 32'h0000_0008, 32'h0000_0008, `OMC_RESP_OKAY);
        axw(`OMC_ADDR_LOCALAC, 32'h0000_0018, `OMC_RESP_OKAY);
        pdReq <= 1'b0;
        tick(3);
        `CHK("centre", ioPinOe[4:3], 2'h3);
        `CHK("cfgerr", cfgErrorOut, 1'b1);
    endtask
    task automatic t_complex();
        axw(`OMC_ADDR_GLOBAL, 32'h0000_0002, `OMC_RESP_OKAY);
        axw(`OMC_ADDR_LOCALAC, 32'h0000_007e, `OMC_RESP_OKAY);
        oeTermIn <= 8'h5a;
        tick(3);
        `CHK("oe", ioPinOe, 8'h5a);
        `CHK("fb", {feedbackOut[7], feedbackOut[0]}, 2'h2);
        `CHK("data", dataPinsOut, 2'h2);
        `CHK("cfgerr", cfgErrorOut, 1'b0);
        axr(`OMC_ADDR_PTCOUNT, 32'hffff_ffff, 32'h7777_7777, `OMC_RESP_OKAY);
        axw(`OMC_ADDR_LOCALAC, 32'h0000_0081, `OMC_RESP_OKAY);
        tick(3);
        `CHK("cfgerr", cfgErrorOut, 1'b1);
    endtask
    // cells 0..3 registered, 4..7 io; registers load only on a shared-clock rise
    task automatic t_registered();
        axw(`OMC_ADDR_GLOBAL, 32'h0000_0000, `OMC_RESP_OKAY);
        axw(`OMC_ADDR_LOCALAC, 32'h0000_00f0, `OMC_RESP_OKAY);
        oeTermIn <= 8'h00;
        sumIn <= 8'h05;
        tick(3);
        `CHK("oeoff", ioPinOe, 8'h00);
        `CHK("data", dataPinsOut, 2'h0);
        runClk <= 1'b1;
        tick(4);
        runClk <= 1'b0;
        oePin <= 1'b0;
        oeTermIn <= 8'h30;
        tick(3);
        `CHK("regout", ioPinOut[3:0] ^ 4'hf, 4'h5);
        `CHK("oeon", ioPinOe, 8'h3f);
        sumIn <= 8'h0a;
        tick(3);
        `CHK("regheld", ioPinOut[3:0] ^ 4'hf, 4'h5);
        axr(`OMC_ADDR_PTCOUNT, 32'hffff_ffff, 32'h7777_8888, `OMC_RESP_OKAY);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // watchdog: the whole sequence needs well under two thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        finish_test();
    end
    initial begin
        {rst_n, clkEn, oePin, runClk, pdReq, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 8'h40;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, sumIn, oeTermIn} = 68'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        extIn = 8'ha5;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_modes();
        t_simple();
        t_complex();
        t_registered();
        finish_test();
    end
endmodule // tb_top
